// ---- fcam_pkg.sv ----
// Constants shared by the fault configuration and alert mask block.
// Assumes nothing beyond a SystemVerilog compiler.
package fcam_pkg;

  // ==========================================================
  // Command codes of the configuration words
  localparam logic [7:0] CMD_OUTPUT_FAULT_DETECT_CFG = 8'hD8;
  localparam logic [7:0] CMD_EXT_TEMP_GAIN = 8'hD9;
  localparam logic [7:0] CMD_EXT_TEMP_BIAS = 8'hDA;
  localparam logic [7:0] CMD_ALERT_PIN_FAULT_MASK = 8'hDB;

  // ==========================================================
  // Widths and counts
  localparam int PAGES = 2;
  localparam int CFG_W = 8;
  localparam int WORD_W = 16;
  localparam int MASK_W = 56;
  localparam int CNT_W = 5;

  // ==========================================================
  // Values after reset
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [15:0] GAIN_RESET = 16'hBA00;
  localparam logic [15:0] BIAS_RESET = 16'h0000;
  localparam logic [55:0] MASK_RESET = 56'h00000000000000;

  // ==========================================================
  // Field positions
  localparam int CFG_LS_ON_BIT = 7;
  localparam int CFG_CNT_LSB = 0;
  localparam int CFG_CNT_MSB = 3;
  localparam int L11_EXP_LSB = 11;
  localparam int L11_EXP_MSB = 15;
  localparam int L11_MAN_MSB = 10;
  localparam int MASK_OTHER_BYTE = 5;
  localparam int TEMP_FRAC = 8;
  localparam int DIV_FRAC = 24;

endpackage

// ---- fcam_qual_if.sv ----
// Link between the register bank and one output's violation qualifier.
// Assumes one clock shared by both ends.
`timescale 1ns/1ns
interface fcam_qual_if;
  logic sample;
  logic ov_viol;
  logic uv_viol;
  logic [3:0] limit;
  logic ov_fault;
  logic uv_fault;

  modport bank (output sample, output ov_viol, output uv_viol, output limit,
                input ov_fault, input uv_fault);
  modport qual (input sample, input ov_viol, input uv_viol, input limit,
                output ov_fault, output uv_fault);
endinterface

// ---- fcam_qualifier.sv ----
// Consecutive violation counters for one output, over and under voltage.
// Assumes samples and violation flags come from logic on the same clock.
`timescale 1ns/1ns
module fcam_qualifier
  import fcam_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Link to the register bank
  fcam_qual_if.qual q
);

  typedef struct packed {
    logic [CNT_W-1:0] ov_cnt;
    logic [CNT_W-1:0] uv_cnt;
    logic ov_fault;
    logic uv_fault;
  } fcam_qual_s;

  fcam_qual_s st;
  fcam_qual_s next_st;

  // Counter step: saturates past the limit, clears on an in-limit sample
  function automatic logic [CNT_W-1:0] step(input logic [CNT_W-1:0] cnt,
                                            input logic viol, input logic [3:0] lim);
    logic [CNT_W-1:0] res;
    res = '0;
    if (viol) begin
      res = (cnt > {1'b0, lim}) ? cnt : cnt + 5'h01;
    end
    return res;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.ov_fault = 1'b0;
    next_st.uv_fault = 1'b0;
    if (q.sample) begin
      next_st.ov_cnt = step(st.ov_cnt, q.ov_viol, q.limit);
      next_st.uv_cnt = step(st.uv_cnt, q.uv_viol, q.limit);
      // Fault on the (N+1)th unbroken violation, once per run
      next_st.ov_fault = q.ov_viol && (st.ov_cnt == {1'b0, q.limit});
      next_st.uv_fault = q.uv_viol && (st.uv_cnt == {1'b0, q.limit});
    end
  end

  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q.ov_fault = st.ov_fault;
  assign q.uv_fault = st.uv_fault;

endmodule

// ---- fcam_top.sv ----
// Fault configuration and alert mask register bank of a power controller.
// Assumes a command engine on the same clock presents decoded writes/reads.
//
// Overview of operation
// - Config bit 7 turns low side on at OV
// - Fault after N+1 consecutive limit violations
// - Config byte resets zero, bits 6:4 unused
// - Per-page config, gain and bias copies
// - Temperature equals input over gain plus bias
// - Gain is Linear-11, resets to BA00h
// - Bias is Linear-11, resets to zero
// - Masked faults never drive the alert pin, except bits in byte 5
// - Mask bytes follow status bytes, byte 5 unused
// - Linear-11 is mantissa times two to exponent
`timescale 1ns/1ns
module fcam_top
  import fcam_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Command port
  input wire logic PAGE,
  input wire logic [7:0] CMD_CODE,
  input wire logic WR_STB,
  input wire logic [MASK_W-1:0] WR_DATA,
  input wire logic RD_STB,
  output logic [MASK_W-1:0] RD_DATA,
  output logic RD_VALID,
  output logic CMD_UNSUP,
  // Limit comparator samples per output
  input wire logic [PAGES-1:0] SAMPLE_STB,
  input wire logic [PAGES-1:0] OV_VIOL,
  input wire logic [PAGES-1:0] UV_VIOL,
  input wire logic [PAGES-1:0] FAULT_CLEAR,
  output logic [PAGES-1:0] OV_FAULT,
  output logic [PAGES-1:0] UV_FAULT,
  output logic [PAGES-1:0] LOW_SIDE_ON,
  // External temperature, signed 1/256 degree units
  input wire logic EXT_TEMP_STB,
  input wire logic EXT_TEMP_PAGE,
  input wire logic [WORD_W-1:0] EXTERNAL_TEMP_INPUT,
  output logic [PAGES-1:0][WORD_W-1:0] TEMP2_OUT,
  // Status bytes and alert pin (open drain, active low)
  input wire logic [MASK_W-1:0] STATUS_IN,
  output logic ALERT_OUTPUT_PIN_O,
  output logic ALERT_OUTPUT_PIN_OE
);

  // All registered state of the bank, one record
  typedef struct packed {
    logic [PAGES-1:0][CFG_W-1:0] cfg;
    logic [PAGES-1:0][WORD_W-1:0] gain;
    logic [PAGES-1:0][WORD_W-1:0] bias;
    logic [MASK_W-1:0] mask;
    logic [MASK_W-1:0] rd_data;
    logic rd_valid;
    logic unsup;
    logic [PAGES-1:0] ls_on;
    logic [PAGES-1:0][WORD_W-1:0] temp2;
    logic alert_oe;
  } fcam_top_s;

  // Present and next copy of the state
  fcam_top_s st;
  fcam_top_s next_st;
  // Mask as applied, unused status byte cleared
  logic [MASK_W-1:0] eff_mask;
  // Registered fault pulses from the qualifiers
  logic [PAGES-1:0] ov_fault;
  logic [PAGES-1:0] uv_fault;

  // ==========================================================
  // Fixed-point helpers
  // Scale by two to a signed power
  function automatic logic signed [47:0] pow2(input logic signed [47:0] v,
                                              input logic signed [5:0] e);
    logic signed [47:0] r;
    r = '0;
    // Right shift keeps the sign, rounds toward minus infinity
    if (e >= 0) begin
      r = v <<< e;
    end else begin
      r = v >>> (-e);
    end
    return r;
  endfunction

  // Linear-11 exponent and mantissa fields
  function automatic logic signed [5:0] l11_exp(input logic [WORD_W-1:0] w);
    return 6'(signed'(w[L11_EXP_MSB:L11_EXP_LSB]));
  endfunction

  function automatic logic signed [47:0] l11_man(input logic [WORD_W-1:0] w);
    return 48'(signed'(w[L11_MAN_MSB:0]));
  endfunction

  // Calibrated reading: input / gain + bias, in 1/256 degree units
  function automatic logic [WORD_W-1:0] calib(input logic [WORD_W-1:0] t,
                                              input logic [WORD_W-1:0] g,
                                              input logic [WORD_W-1:0] b);
    logic signed [47:0] q;
    logic signed [47:0] o;
    // Divide first with spare fraction bits, so small gains lose little
    q = (48'(signed'(t)) <<< DIV_FRAC) / l11_man(g);
    // Reciprocal of the gain exponent, then drop the spare fraction
    q = pow2(q, -l11_exp(g)) >>> DIV_FRAC;
    // Bias brought to 1/256 degree units
    o = pow2(l11_man(b), l11_exp(b) + 6'(TEMP_FRAC));
    // Wraps past 16 bits; sane gain and bias keep it in range
    return WORD_W'(q + o);
  endfunction

  // ==========================================================
  // Per-output violation qualifiers
  fcam_qual_if qif[PAGES] ();

  // Comparator flags pass straight through, same clock
  for (genvar g = 0; g < PAGES; g++) begin : gen_qual
    assign qif[g].sample = SAMPLE_STB[g];
    assign qif[g].ov_viol = OV_VIOL[g];
    assign qif[g].uv_viol = UV_VIOL[g];
    assign qif[g].limit = st.cfg[g][CFG_CNT_MSB:CFG_CNT_LSB];
    assign ov_fault[g] = qif[g].ov_fault;
    assign uv_fault[g] = qif[g].uv_fault;
    fcam_qualifier u_qual (
      .clk(CLK),
      .arst_n(ARST_N),
      .q(qif[g])
    );
  end

  // Byte 5 of the mask has no effect
  // It is still stored and read back as written
  always_comb begin
    eff_mask = st.mask;
    eff_mask[MASK_OTHER_BYTE*8 +: 8] = 8'h00;
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    // Answer flags are single-cycle pulses
    next_st.rd_valid = 1'b0;
    next_st.unsup = 1'b0;
    // Register writes, paged words go to the selected copy
    if (WR_STB) begin
      unique case (CMD_CODE)
        CMD_OUTPUT_FAULT_DETECT_CFG: next_st.cfg[PAGE] = WR_DATA[CFG_W-1:0];
        CMD_EXT_TEMP_GAIN: next_st.gain[PAGE] = WR_DATA[WORD_W-1:0];
        CMD_EXT_TEMP_BIAS: next_st.bias[PAGE] = WR_DATA[WORD_W-1:0];
        CMD_ALERT_PIN_FAULT_MASK: next_st.mask = WR_DATA;
        default: next_st.unsup = 1'b1;
      endcase
    end
    // Register reads, unmapped codes read zero
    if (RD_STB) begin
      next_st.rd_valid = 1'b1;
      unique case (CMD_CODE)
        CMD_OUTPUT_FAULT_DETECT_CFG: next_st.rd_data = MASK_W'(st.cfg[PAGE]);
        CMD_EXT_TEMP_GAIN: next_st.rd_data = MASK_W'(st.gain[PAGE]);
        CMD_EXT_TEMP_BIAS: next_st.rd_data = MASK_W'(st.bias[PAGE]);
        CMD_ALERT_PIN_FAULT_MASK: next_st.rd_data = st.mask;
        default: begin
          next_st.rd_data = '0;
          next_st.unsup = 1'b1;
        end
      endcase
    end
    // Low-side drive on OV shutdown; set wins over clear
    for (int p = 0; p < PAGES; p++) begin
      if (FAULT_CLEAR[p]) begin
        next_st.ls_on[p] = 1'b0;
      end
      if (ov_fault[p] && st.cfg[p][CFG_LS_ON_BIT]) begin
        next_st.ls_on[p] = 1'b1;
      end
    end
    // Second temperature, skipped while the gain mantissa is zero
    // A zero divisor would make the reading meaningless
    if (EXT_TEMP_STB && (l11_man(st.gain[EXT_TEMP_PAGE]) != 0)) begin
      next_st.temp2[EXT_TEMP_PAGE] = calib(EXTERNAL_TEMP_INPUT,
                                           st.gain[EXT_TEMP_PAGE],
                                           st.bias[EXT_TEMP_PAGE]);
    end
    // Alert pulls low for any unmasked status bit
    // Registered, so the pin does not glitch on status changes
    next_st.alert_oe = |(STATUS_IN & ~eff_mask);
  end

  // ==========================================================
  // State register, reset values per field over a cleared record
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st <= '0;
      st.cfg <= {PAGES{CFG_RESET}};
      st.gain <= {PAGES{GAIN_RESET}};
      st.bias <= {PAGES{BIAS_RESET}};
      st.mask <= MASK_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  // Command answers
  assign RD_DATA = st.rd_data;
  assign RD_VALID = st.rd_valid;
  assign CMD_UNSUP = st.unsup;

  // Fault pulses and low-side drive level
  assign OV_FAULT = ov_fault;
  assign UV_FAULT = uv_fault;
  assign LOW_SIDE_ON = st.ls_on;

  // Calibrated readings
  assign TEMP2_OUT = st.temp2;

  // Alert pin, open drain
  assign ALERT_OUTPUT_PIN_O = 1'b0; // Open drain drives only low
  assign ALERT_OUTPUT_PIN_OE = st.alert_oe;

endmodule

// ---- fcam_assertions.sv ----
// Port assertions for the fault config and alert mask bank.
// Assumes the top module's single clock and asynchronous low reset.
`timescale 1ns/1ns
module fcam_assertions
  import fcam_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Command port
  input wire logic [7:0] CMD_CODE,
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic RD_VALID,
  input wire logic CMD_UNSUP,
  // Fault qualification and alert
  input wire logic [PAGES-1:0] SAMPLE_STB,
  input wire logic [PAGES-1:0] OV_VIOL,
  input wire logic [PAGES-1:0] FAULT_CLEAR,
  input wire logic [PAGES-1:0] OV_FAULT,
  input wire logic [PAGES-1:0] LOW_SIDE_ON,
  input wire logic [MASK_W-1:0] STATUS_IN,
  input wire logic ALERT_OUTPUT_PIN_OE
);
  // ==========================================================
  // Clocking, decode and sample sequences
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  logic mapped;
  assign mapped = CMD_CODE >= CMD_OUTPUT_FAULT_DETECT_CFG && CMD_CODE <= CMD_ALERT_PIN_FAULT_MASK;
  sequence ov_hit; SAMPLE_STB[0] && OV_VIOL[0]; endsequence
  sequence ov_miss; SAMPLE_STB[0] && !OV_VIOL[0]; endsequence
  // ==========================================================
  // Properties
  chk_read_answer: assert property (RD_VALID == $past(RD_STB))
    else $error("read answer timing wrong");
  chk_unsup_code: assert property (CMD_UNSUP == $past((RD_STB || WR_STB) && !mapped))
    else $error("unsupported flag wrong");
  chk_miss_clears: assert property (ov_miss |=> !OV_FAULT[0])
    else $error("fault after in-limit sample");
  chk_fault_cause: assert property (OV_FAULT[0] |-> $past(SAMPLE_STB[0] && OV_VIOL[0]))
    else $error("fault without violating sample");
  chk_fault_single: assert property (ov_hit ##1 OV_FAULT[0] |=> !OV_FAULT[0])
    else $error("fault pulse too long");
  chk_ls_cause: assert property ($rose(LOW_SIDE_ON[0]) |-> $past(OV_FAULT[0]))
    else $error("low side on without fault");
  chk_ls_hold: assert property (LOW_SIDE_ON[0] && !FAULT_CLEAR[0] |=> LOW_SIDE_ON[0])
    else $error("low side dropped early");
  chk_alert_quiet: assert property ($past(STATUS_IN) == '0 |-> !ALERT_OUTPUT_PIN_OE)
    else $error("alert with no fault");
endmodule

bind fcam_top fcam_assertions fcam_assertions_inst (.CLK(CLK), .ARST_N(ARST_N),
  .CMD_CODE(CMD_CODE), .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_VALID(RD_VALID),
  .CMD_UNSUP(CMD_UNSUP), .SAMPLE_STB(SAMPLE_STB), .OV_VIOL(OV_VIOL),
  .FAULT_CLEAR(FAULT_CLEAR), .OV_FAULT(OV_FAULT), .LOW_SIDE_ON(LOW_SIDE_ON),
  .STATUS_IN(STATUS_IN), .ALERT_OUTPUT_PIN_OE(ALERT_OUTPUT_PIN_OE));

// ---- fcam_host.sv ----
// Host model issuing whole-word configuration writes and reads.
// Assumes the bank answers a read one cycle after taking it.
`timescale 1ns/1ns
module fcam_host
  import fcam_pkg::*;
(
  // Clock
  input wire logic clk,
  // Command port towards the bank
  output logic page = 1'b0,
  output logic [7:0] cmd_code = 8'h00,
  output logic wr_stb = 1'b0,
  output logic [MASK_W-1:0] wr_data = '0,
  output logic rd_stb = 1'b0,
  input wire logic [MASK_W-1:0] rd_data,
  input wire logic rd_valid
);
  // One write; data inverted once released
  task automatic wr(input logic p, input logic [7:0] c, input logic [MASK_W-1:0] d);
    @(posedge clk);
    page <= p;
    cmd_code <= c;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    wr_data <= ~d;
  endtask
  // One read; answer awaited a bounded time
  task automatic rd(input logic p, input logic [7:0] c, output logic [MASK_W-1:0] d,
                    output logic ok);
    ok = 1'b0;
    d = '0;
    @(posedge clk);
    page <= p;
    cmd_code <= c;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    // Answer stands in the cycle after the taking edge; look once settled
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      ok = (rd_valid === 1'b1);
      d = rd_data;
      if (!ok) begin
        @(posedge clk);
      end
    end
  endtask
endmodule

// ---- tb.sv ----
// Self-checking bench for the fault config and alert mask bank.
// Assumes the host model and the bound checker.
`timescale 1ns/1ns
module tb;
  import fcam_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, page, wr_stb, rd_stb, rd_valid, alert_o, alert_oe;
  logic ext_stb = 1'b0, ext_page = 1'b0;
  logic [7:0] cmd_code;
  logic [MASK_W-1:0] wr_data, rd_data, status = '0;
  logic [PAGES-1:0] smp = '0, ov = '0, uv = '0, clr = '0, ov_f, uv_f, ls_on;
  logic [WORD_W-1:0] ext_t = '0;
  logic [PAGES-1:0][WORD_W-1:0] temp2;
  int fails = 0, checks = 0;
  // ==========================================================
  // Clock, design and host
  always #5 clk = ~clk;
  fcam_top fcam_top_inst (.CLK(clk), .ARST_N(arst_n), .PAGE(page), .CMD_CODE(cmd_code),
    .WR_STB(wr_stb), .WR_DATA(wr_data), .RD_STB(rd_stb), .RD_DATA(rd_data),
    .RD_VALID(rd_valid), .CMD_UNSUP(), .SAMPLE_STB(smp), .OV_VIOL(ov), .UV_VIOL(uv),
    .FAULT_CLEAR(clr), .OV_FAULT(ov_f), .UV_FAULT(uv_f), .LOW_SIDE_ON(ls_on),
    .EXT_TEMP_STB(ext_stb), .EXT_TEMP_PAGE(ext_page), .EXTERNAL_TEMP_INPUT(ext_t),
    .TEMP2_OUT(temp2), .STATUS_IN(status), .ALERT_OUTPUT_PIN_O(alert_o),
    .ALERT_OUTPUT_PIN_OE(alert_oe));
  fcam_host fcam_host_inst (.clk(clk), .page(page), .cmd_code(cmd_code), .wr_stb(wr_stb),
    .wr_data(wr_data), .rd_stb(rd_stb), .rd_data(rd_data), .rd_valid(rd_valid));
  // ==========================================================
  // Compare, read-and-compare, verdict
  task automatic cmp(input logic [MASK_W-1:0] got, input logic [MASK_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic p, input logic [7:0] c, input logic [MASK_W-1:0] exp);
    logic [MASK_W-1:0] d;
    logic ok;
    fcam_host_inst.rd(p, c, d, ok);
    if (!ok) begin
      fails++;
      $display("FAIL %0t read answer missing", $time);
      results();
    end else begin
      cmp(d, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    rdc(1'b1, CMD_OUTPUT_FAULT_DETECT_CFG, 56'h0);
    rdc(1'b1, CMD_EXT_TEMP_GAIN, 56'hBA00);
    rdc(1'b1, CMD_EXT_TEMP_BIAS, 56'h0);
    rdc(1'b0, CMD_ALERT_PIN_FAULT_MASK, 56'h0);
    fcam_host_inst.wr(1'b0, CMD_OUTPUT_FAULT_DETECT_CFG, 56'h81);
    fcam_host_inst.wr(1'b1, CMD_OUTPUT_FAULT_DETECT_CFG, 56'h70);
    fcam_host_inst.wr(1'b0, CMD_ALERT_PIN_FAULT_MASK, 56'hFFFF00000000FF);
    fcam_host_inst.wr(1'b0, 8'hD7, 56'h12);
    rdc(1'b0, 8'hD7, 56'h0);
    rdc(1'b0, CMD_OUTPUT_FAULT_DETECT_CFG, 56'h81);
    rdc(1'b1, CMD_ALERT_PIN_FAULT_MASK, 56'hFFFF00000000FF);
  endtask
  task automatic t_fault();
    logic [2:0] sq [7] = '{3'b010, 3'b000, 3'b010, 3'b010, 3'b010, 3'b101, 3'b110};
    logic [1:0] ex [7] = '{2'b00, 2'b00, 2'b00, 2'b10, 2'b00, 2'b01, 2'b10};
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      smp[sq[i][2]] <= 1'b1;
      ov[sq[i][2]] <= sq[i][1];
      uv[sq[i][2]] <= sq[i][0];
      @(posedge clk);
      smp <= '0;
      // Fault pulse stands only in the cycle after the taking edge
      #1;
      cmp(56'({ov_f[sq[i][2]], uv_f[sq[i][2]]}), 56'(ex[i]));
    end
    cmp(56'(ls_on), 56'h1);
    @(posedge clk);
    clr <= 2'b01;
    @(posedge clk);
    clr <= 2'b00;
    repeat (2) @(posedge clk);
    cmp(56'(ls_on), 56'h0);
  endtask
  task automatic t_temp();
    logic [WORD_W-1:0] tg [3] = '{16'hBA00, 16'h0002, 16'hF801};
    logic [WORD_W-1:0] tb_ [3] = '{16'h0000, 16'h000A, 16'h07F6};
    logic [WORD_W-1:0] te [3] = '{16'h1900, 16'h1680, 16'h2800};
    for (int i = 0; i < 3; i++) begin
      fcam_host_inst.wr(i[0], CMD_EXT_TEMP_GAIN, 56'(tg[i]));
      fcam_host_inst.wr(i[0], CMD_EXT_TEMP_BIAS, 56'(tb_[i]));
      ext_stb <= 1'b1;
      ext_page <= i[0];
      ext_t <= 16'h1900;
      @(posedge clk);
      ext_stb <= 1'b0;
      ext_t <= 16'hE6FF;
      repeat (2) @(posedge clk);
      cmp(56'(temp2[i[0]]), 56'(te[i]));
    end
    rdc(1'b1, CMD_EXT_TEMP_GAIN, 56'h0002);
    // Zero gain mantissa leaves the last reading standing
    fcam_host_inst.wr(1'b1, CMD_EXT_TEMP_GAIN, 56'h0);
    ext_stb <= 1'b1;
    ext_page <= 1'b1;
    ext_t <= 16'h1900;
    @(posedge clk);
    ext_stb <= 1'b0;
    repeat (2) @(posedge clk);
    cmp(56'(temp2[1]), 56'(te[1]));
  endtask
  task automatic t_alert();
    logic [MASK_W-1:0] st [4] = '{56'h1, 56'h100, 56'h10000000000, 56'h1000000000000};
    logic ea [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++) begin
      status <= st[i];
      repeat (3) @(posedge clk);
      cmp(56'(alert_oe), 56'(ea[i]));
    end
    cmp(56'(alert_o), 56'h0);
  endtask
  // Reset, then scenarios in order
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_fault();
    t_temp();
    @(posedge clk);
    t_alert();
    results();
  end
endmodule
